// file: logic/dts_pkg.sv
package dts_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register indices (word index; byte address is four times the index)
  localparam logic [7:0] DTS_IDX_HIGH = 8'h11;
  localparam logic [7:0] DTS_IDX_LOW = 8'h12;
  localparam logic [7:0] DTS_IDX_CTRL = 8'h13;
  localparam logic [7:0] DTS_IDX_STAT = 8'h14;

  // Register select codes
  localparam logic [2:0] DTS_SEL_NONE = 3'h0;
  localparam logic [2:0] DTS_SEL_HIGH = 3'h1;
  localparam logic [2:0] DTS_SEL_LOW = 3'h2;
  localparam logic [2:0] DTS_SEL_CTRL = 3'h3;
  localparam logic [2:0] DTS_SEL_STAT = 3'h4;

  // Field positions and reset values
  localparam int DTS_CTRL_EN_BIT = 0;
  localparam int DTS_STAT_HIGH_RUN_BIT = 0;
  localparam int DTS_STAT_LOW_RUN_BIT = 1;
  localparam int DTS_STAT_GEN_ON_BIT = 2;
  localparam int DTS_STAT_PIN_BIT = 3;
  localparam logic [7:0] DTS_DIV_RST = 8'h00;
  localparam logic DTS_EN_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Waveform shape
  localparam logic [4:0] DTS_STEPS = 5'h17;
  localparam logic [4:0] DTS_HIGH_STEPS = 5'h0C;
  localparam logic signed [9:0] DTS_HI_GAIN = 10'sh100;
  localparam logic signed [9:0] DTS_LO_GAIN = 10'sh0CB;
  localparam logic [9:0] DTS_DAC_MID = 10'h200;

  typedef logic [2:0] dts_sel_t;

  // Address decode shared by write and read paths
  function automatic dts_sel_t dts_decode(input logic [31:0] addr);
    dts_sel_t sel;
    sel = DTS_SEL_NONE;
    if (addr[31:10] == 22'h000000)
    begin
      case (addr[9:2])
        DTS_IDX_HIGH: sel = DTS_SEL_HIGH;
        DTS_IDX_LOW: sel = DTS_SEL_LOW;
        DTS_IDX_CTRL: sel = DTS_SEL_CTRL;
        DTS_IDX_STAT: sel = DTS_SEL_STAT;
        default: sel = DTS_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // One sine period in 23 signed samples
  function automatic logic signed [7:0] dts_sine(input logic [4:0] ph);
    logic signed [7:0] s;
    s = 8'sh00;
    case (ph)
      5'h01: s = 8'sh22;
      5'h02: s = 8'sh42;
      5'h03: s = 8'sh5E;
      5'h04: s = 8'sh71;
      5'h05: s = 8'sh7D;
      5'h06: s = 8'sh7E;
      5'h07: s = 8'sh77;
      5'h08: s = 8'sh66;
      5'h09: s = 8'sh4E;
      5'h0A: s = 8'sh30;
      5'h0B: s = 8'sh11;
      5'h0C: s = 8'shEF;
      5'h0D: s = 8'shD0;
      5'h0E: s = 8'shB2;
      5'h0F: s = 8'sh9A;
      5'h10: s = 8'sh89;
      5'h11: s = 8'sh82;
      5'h12: s = 8'sh83;
      5'h13: s = 8'sh8F;
      5'h14: s = 8'shA2;
      5'h15: s = 8'shBE;
      5'h16: s = 8'shDE;
      default: s = 8'sh00;
    endcase
    return s;
  endfunction

endpackage

// file: logic/dts_synth.sv
`timescale 1ns/1ps
module dts_synth
  import dts_pkg::*;
(
  input logic core_clk,
  input logic rst,
  input logic [7:0] divisor,
  output logic running,
  output logic signed [7:0] sample,
  output logic square
);

  logic [8:0] cnt_ff;
  logic [4:0] phase_ff;
  logic running_ff;
  logic signed [7:0] sample_ff;
  logic square_ff;
  logic halt;
  logic wrap;

  ////////////////////////////////////////////////////////////////////////
  // Zero divisor stops this synthesizer
  assign halt = (divisor == 8'h00);
  // One phase step every x+2 clocks
  assign wrap = (cnt_ff >= ({1'b0, divisor} + 9'h001));

  // Step prescaler
  always_ff @(posedge core_clk)
  begin
    if (rst || halt)
      cnt_ff <= 9'h000;
    else if (wrap)
      cnt_ff <= 9'h000;
    else
      cnt_ff <= cnt_ff + 9'h001;
  end

  // Phase walks 23 steps per period
  always_ff @(posedge core_clk)
  begin
    if (rst || halt)
      phase_ff <= 5'h00;
    else if (wrap)
      phase_ff <= (phase_ff == DTS_STEPS - 5'h01) ? 5'h00 : phase_ff + 5'h01;
  end

  // Sine and square from the same phase, side by side
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sample_ff <= 8'sh00;
      square_ff <= 1'b0;
      running_ff <= 1'b0;
    end
    else
    begin
      sample_ff <= halt ? 8'sh00 : dts_sine(phase_ff);
      square_ff <= !halt && (phase_ff < DTS_HIGH_STEPS);
      running_ff <= !halt;
    end
  end

  assign running = running_ff;
  assign sample = sample_ff;
  assign square = square_ff;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_steady;
    (divisor != 8'h00) && $stable(divisor) && (divisor == $past(divisor, 2));
  endsequence

  a_halt_clears: assert property (halt
      |=> (phase_ff == 5'h00) && !square_ff)
    else $error("halted synth kept phase");
  a_step_period: assert property (s_steady ##0 $changed(phase_ff)
      |-> $past(cnt_ff) == ({1'b0, $past(divisor)} + 9'h001))
    else $error("phase step not after x+2 clocks");
  a_duty_fall: assert property ($fell(square_ff) && running_ff
      |-> $past(phase_ff) == DTS_HIGH_STEPS)
    else $error("square fell at wrong phase");
  a_duty_rise: assert property ($rose(square_ff)
      |-> $past(phase_ff) == 5'h00)
    else $error("square rose at wrong phase");
  a_sine_follow: assert property (!halt ##1 !halt
      |-> sample_ff == dts_sine($past(phase_ff)))
    else $error("sine sample not from phase");

endmodule

// file: logic/dts_top.sv
`timescale 1ns/1ps
module dts_top
  import dts_pkg::*;
(
  input logic core_clk,
  input logic rst,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input logic port_bit,
  input logic shared_square_wave_pin_i,
  output logic shared_square_wave_pin_o,
  output logic shared_square_wave_pin_oe,
  output logic [9:0] tone_code,
  output logic tone_oe
);

  logic wr_pend_ff;
  dts_sel_t wr_sel_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [7:0] high_tone_divisor_ff;
  logic [7:0] low_tone_divisor_ff;
  logic square_wave_enable_ff;
  logic gen_on_ff;
  logic tone_oe_ff;
  logic [9:0] tone_code_ff;
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic pin_o_ff;
  logic pin_oe_ff;
  logic take;
  dts_sel_t rd_sel;
  logic [31:0] nxt_rdata;
  logic nxt_pin;
  logic signed [17:0] mix;
  logic [7:0] div_w [2];
  logic run_w [2];
  logic square_w [2];
  logic signed [7:0] sample_w [2];

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase
  assign take = hsel && hready && htrans[1];
  assign rd_sel = dts_decode(haddr);

  // Pending write remembered for the data phase
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_pend_ff <= 1'b0;
      wr_sel_ff <= DTS_SEL_NONE;
    end
    else
    begin
      wr_pend_ff <= take && hwrite;
      wr_sel_ff <= take ? rd_sel : DTS_SEL_NONE;
    end
  end

  // Read data; divisors are write-only and read as zero
  always_comb
  begin
    nxt_rdata = 32'h00000000;
    case (rd_sel)
      DTS_SEL_CTRL: nxt_rdata[DTS_CTRL_EN_BIT] = square_wave_enable_ff;
      DTS_SEL_STAT:
      begin
        nxt_rdata[DTS_STAT_HIGH_RUN_BIT] = run_w[0];
        nxt_rdata[DTS_STAT_LOW_RUN_BIT] = run_w[1];
        nxt_rdata[DTS_STAT_GEN_ON_BIT] = gen_on_ff;
        nxt_rdata[DTS_STAT_PIN_BIT] = pin_sync_ff;
      end
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // Zero wait state, always OKAY
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
    else
    begin
      hrdata_ff <= (take && !hwrite) ? nxt_rdata : 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes in the data phase
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      high_tone_divisor_ff <= DTS_DIV_RST;
      low_tone_divisor_ff <= DTS_DIV_RST;
      square_wave_enable_ff <= DTS_EN_RST;
    end
    else if (wr_pend_ff)
    begin
      if (wr_sel_ff == DTS_SEL_HIGH)
        high_tone_divisor_ff <= hwdata[7:0];
      if (wr_sel_ff == DTS_SEL_LOW)
        low_tone_divisor_ff <= hwdata[7:0];
      if (wr_sel_ff == DTS_SEL_CTRL)
        square_wave_enable_ff <= hwdata[DTS_CTRL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two synthesizers: index 0 high group, index 1 low group
  assign div_w[0] = high_tone_divisor_ff;
  assign div_w[1] = low_tone_divisor_ff;

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_synth
      dts_synth u_synth (
        .core_clk(core_clk),
        .rst(rst || !gen_on_ff),
        .divisor(div_w[g]),
        .running(run_w[g]),
        .sample(sample_w[g]),
        .square(square_w[g])
      );
    end
  endgenerate

  // Weighted sum; low gain 203/256 is about -2 dB
  assign mix = 18'(sample_w[0] * DTS_HI_GAIN)
    + 18'(sample_w[1] * DTS_LO_GAIN);

  // Generator power, tone code and tone float
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      gen_on_ff <= 1'b0;
      tone_oe_ff <= 1'b0;
      tone_code_ff <= DTS_DAC_MID;
    end
    else
    begin
      gen_on_ff <= (high_tone_divisor_ff != 8'h00)
        || (low_tone_divisor_ff != 8'h00);
      tone_oe_ff <= gen_on_ff;
      // Offset binary; divisors below 60 are removed by the analog filter
      tone_code_ff <= gen_on_ff ? {~mix[16], mix[15:7]}
        : DTS_DAC_MID;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end
    else
    begin
      pin_meta_ff <= shared_square_wave_pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Pin source select; melody is ANDed with the port flip-flop
  always_comb
  begin
    nxt_pin = port_bit;
    if (square_wave_enable_ff)
    begin
      if (high_tone_divisor_ff == 8'h00)
        nxt_pin = 1'b1;
      else
        nxt_pin = square_w[0] && port_bit;
    end
  end

  // Quasi-bidirectional drive: strong low, weak pull-up outside
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_o_ff <= 1'b1;
      pin_oe_ff <= 1'b0;
    end
    else
    begin
      pin_o_ff <= nxt_pin;
      pin_oe_ff <= !nxt_pin;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign shared_square_wave_pin_o = pin_o_ff;
  assign shared_square_wave_pin_oe = pin_oe_ff;
  assign tone_code = tone_code_ff;
  assign tone_oe = tone_oe_ff;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_both_zero;
    (high_tone_divisor_ff == 8'h00) && (low_tone_divisor_ff == 8'h00);
  endsequence

  a_high_write: assert property (wr_pend_ff
      && wr_sel_ff == DTS_SEL_HIGH
      |=> high_tone_divisor_ff == $past(hwdata[7:0]))
    else $error("high divisor write lost");
  a_power_off: assert property (s_both_zero ##1 s_both_zero
      |-> !gen_on_ff ##1 (!tone_oe_ff && tone_code_ff == DTS_DAC_MID))
    else $error("generator not shut off");
  a_tone_float: assert property (!gen_on_ff |=> !tone_oe_ff)
    else $error("tone driven with no tone");
  a_pin_idle_high: assert property (square_wave_enable_ff
      && high_tone_divisor_ff == 8'h00 |=> pin_o_ff && !pin_oe_ff)
    else $error("melody pin not high");
  a_port_mode: assert property (!square_wave_enable_ff
      |=> pin_o_ff == $past(port_bit))
    else $error("port value not on pin");
  a_melody_src: assert property (square_wave_enable_ff && port_bit
      && high_tone_divisor_ff != 8'h00 |=> pin_o_ff == $past(square_w[0]))
    else $error("melody not from high synth");
  a_high_gain: assert property (gen_on_ff && sample_w[0] == 8'sh7E
      && sample_w[1] == 8'sh00 |=> tone_code_ff == 10'h2FC)
    else $error("high group level wrong");
  a_low_gain: assert property (gen_on_ff && sample_w[0] == 8'sh00
      && sample_w[1] == 8'sh7E |=> tone_code_ff == 10'h2C7)
    else $error("low group not 2 dB down");
  a_bus_okay: assert property (hreadyout_ff && !hresp_ff)
    else $error("bus not ready or error");

  // Remaining writes, the read side of the map and synth halting
  a_low_write: assert property (wr_pend_ff
      && wr_sel_ff == DTS_SEL_LOW
      |=> low_tone_divisor_ff == $past(hwdata[7:0]))
    else $error("low divisor write lost");
  a_ctrl_write: assert property (wr_pend_ff
      && wr_sel_ff == DTS_SEL_CTRL
      |=> square_wave_enable_ff == $past(hwdata[DTS_CTRL_EN_BIT]))
    else $error("enable write lost");
  a_stray_write: assert property (wr_pend_ff
      && (wr_sel_ff == DTS_SEL_NONE || wr_sel_ff == DTS_SEL_STAT)
      |=> $stable(high_tone_divisor_ff) && $stable(low_tone_divisor_ff)
      && $stable(square_wave_enable_ff))
    else $error("stray write changed a register");
  a_div_read_zero: assert property (take && !hwrite
      && (rd_sel == DTS_SEL_HIGH || rd_sel == DTS_SEL_LOW)
      |=> hrdata_ff == 32'h00000000)
    else $error("write-only divisor read back");
  a_ctrl_read: assert property (take && !hwrite
      && rd_sel == DTS_SEL_CTRL
      |=> hrdata_ff[DTS_CTRL_EN_BIT] == $past(square_wave_enable_ff))
    else $error("enable read back wrong");
  a_stat_read: assert property (take && !hwrite
      && rd_sel == DTS_SEL_STAT
      |=> hrdata_ff[DTS_STAT_GEN_ON_BIT] == $past(gen_on_ff))
    else $error("generator state read wrong");
  a_rdata_idle: assert property (!(take && !hwrite)
      |=> hrdata_ff == 32'h00000000)
    else $error("read data left on bus");
  a_gen_wake: assert property (high_tone_divisor_ff != 8'h00
      || low_tone_divisor_ff != 8'h00 |=> gen_on_ff ##1 tone_oe_ff)
    else $error("generator stayed off");
  a_high_halt: assert property (high_tone_divisor_ff == 8'h00
      |=> sample_w[0] == 8'sh00 && !run_w[0])
    else $error("high synth not halted");
  a_low_halt: assert property (low_tone_divisor_ff == 8'h00
      |=> sample_w[1] == 8'sh00 && !run_w[1])
    else $error("low synth not halted");

endmodule

// file: test/dts_ringer_model.sv
`timescale 1ns/1ps
module dts_ringer_model
  import dts_pkg::*;
(
  input wire logic core_clk,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic [9:0] tone_code,
  input wire logic tone_oe,
  input wire logic peak_clr,
  output logic pin_lvl,
  output int high_len,
  output int period,
  output logic [9:0] peak
);
  logic prev_ff;
  int cnt_ff;
  int hc_ff;

  ////////////////////////////////////////////////////////////////////////
  // Pin is pulled up whenever the block releases it
  assign pin_lvl = (pin_oe & ~pin_o) ? 1'b0 : 1'b1;

  // Ringer measures period and high time of the pin level
  always @(posedge core_clk)
  begin
    prev_ff <= pin_lvl;
    if (pin_lvl & ~prev_ff)
    begin
      period <= cnt_ff;
      cnt_ff <= 1;
    end
    else
      cnt_ff <= cnt_ff + 1;
    if (pin_lvl)
      hc_ff <= hc_ff + 1;
    else
    begin
      if (prev_ff)
        high_len <= hc_ff;
      hc_ff <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line keeps the highest code seen while the tone pin is driven
  always @(posedge core_clk)
  begin
    if (peak_clr)
      peak <= 10'h000;
    else if (tone_oe && tone_code > peak)
      peak <= tone_code;
  end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench
  import dts_pkg::*;
;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} dts_row_s;
  logic core_clk, rst, hsel, hwrite, port_bit, peak_clr;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, pin_lvl, pin_o, pin_oe, tone_oe;
  logic [9:0] tone_code, peak;
  int high_len, period, num_errors, samples_checked;
  // Writes then reads: divisors, control, unmapped, status
  dts_row_s rows[6] = '{'{32'h44, 32'hAF, 32'h0}, '{32'h48, 32'hDD, 32'h0},
    '{32'h4C, 32'hFF, 32'h1}, '{32'h4C, 32'h00, 32'h0},
    '{32'h60, 32'h55, 32'h0}, '{32'h50, 32'hFF, 32'hF}};

  dts_top i_dts_top (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_bit(port_bit),
    .shared_square_wave_pin_i(pin_lvl), .shared_square_wave_pin_o(pin_o),
    .shared_square_wave_pin_oe(pin_oe), .tone_code(tone_code),
    .tone_oe(tone_oe));
  dts_ringer_model i_dts_ringer_model (.core_clk(core_clk), .pin_o(pin_o),
    .pin_oe(pin_oe), .tone_code(tone_code), .tone_oe(tone_oe),
    .peak_clr(peak_clr), .pin_lvl(pin_lvl), .high_len(high_len),
    .period(period), .peak(peak));

  ////////////////////////////////////////////////////////////////////////
  // Clock, helpers and bus master
  always #2 core_clk = ~core_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic ahb(input logic [31:0] a, input logic w,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask
  task automatic pk_clear();
    peak_clr <= 1'b1;
    cyc(1);
    peak_clr <= 1'b0;
  endtask
  task automatic rst_chk();
    chk({hreadyout, hresp, pin_o, pin_oe, tone_oe}, 32'h14, "reset outs");
    chk(tone_code, DTS_DAC_MID, "reset tone");
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog cuts a hang short
  initial
  begin
    #200000;
    num_errors++;
    $display("watchdog expired");
    close_out();
  end

  // Main sequence
  initial
  begin
    {core_clk, hsel, hwrite, peak_clr} = 4'h0;
    {haddr, hwdata, htrans, num_errors, samples_checked} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    port_bit = 1'b1;
    cyc(10);
    rst_chk();
    $display("reset check done");
    rst <= 1'b0;
    cyc(1);
    foreach (rows[i])
    begin
      ahb(rows[i].a, 1'b1, rows[i].d);
      ahb(rows[i].a, 1'b0, 32'h0);
      chk(r, rows[i].e, "register read");
    end
    $display("register table done");
    ahb(32'h44, 1'b1, 32'h0);
    ahb(32'h4C, 1'b1, 32'h1);
    pk_clear();
    cyc(5200);
    chk(pin_lvl, 1'b1, "pin held high");
    chk(peak, 10'h2C7, "low tone peak");
    $display("low tone only done");
    ahb(32'h48, 1'b1, 32'h0);
    ahb(32'h44, 1'b1, 32'h2);
    cyc(400);
    chk(period, 92, "square period");
    chk(high_len, 48, "square high");
    pk_clear();
    cyc(100);
    chk(tone_oe, 1'b1, "tone beside square");
    chk(peak, 10'h2FC, "high tone peak");
    ahb(32'h48, 1'b1, 32'h10);
    cyc(400);
    chk(period, 92, "square ignores low");
    ahb(32'h48, 1'b1, 32'h0);
    ahb(32'h44, 1'b1, 32'h80);
    cyc(6200);
    chk(period, 32'hBAE, "1200 Hz carrier");
    ahb(32'h44, 1'b1, 32'h45);
    cyc(3400);
    chk(period, 32'h661, "2200 Hz carrier");
    $display("square wave done");
    ahb(32'h4C, 1'b1, 32'h0);
    port_bit <= 1'b0;
    cyc(4);
    chk(pin_lvl, 1'b0, "port line low");
    port_bit <= 1'b1;
    cyc(4);
    chk(pin_lvl, 1'b1, "port line high");
    $display("port line done");
    ahb(32'h48, 1'b1, 32'h0);
    ahb(32'h44, 1'b1, 32'h0);
    cyc(4);
    chk(tone_oe, 1'b0, "tone floats");
    chk(tone_code, DTS_DAC_MID, "tone idle");
    ahb(32'h50, 1'b0, 32'h0);
    chk(r, 32'h8, "generator off");
    $display("shutdown done");
    ahb(32'h44, 1'b1, 32'h5);
    ahb(32'h4C, 1'b1, 32'h1);
    rst <= 1'b1;
    cyc(2);
    rst_chk();
    rst <= 1'b0;
    cyc(4);
    ahb(32'h4C, 1'b0, 32'h0);
    chk(r, 32'h0, "control after reset");
    $display("mid-run reset done");
    close_out();
  end
endmodule
